// File: cbs_bus_if.sv
// Bus cycle request carried from the sequencer to the pin driver.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface cbs_bus_if;
    logic        valid_memory_qualifier;
    logic [15:0] addr;
    logic        rd;
    logic [7:0]  wdata;
    logic        float_bus;
    modport seq (output valid_memory_qualifier, addr, rd, wdata, float_bus);
    modport pin (input valid_memory_qualifier, addr, rd, wdata, float_bus);
endinterface

// File: cbs_defs.svh
// Constants for the bus cycle sequencer: vectors, offsets, cycle counts.
// Assumes inclusion by bare name from the sequencer design file.
`ifndef CBS_DEFS_SVH
`define CBS_DEFS_SVH
`define CBS_VEC_HI       16'hFFFA
`define CBS_VEC_LO       16'hFFFB
`define CBS_CYC_INH      4'h2
`define CBS_CYC_REG      4'h4
`define CBS_CYC_PSH      4'h4
`define CBS_CYC_RTS      4'h5
`define CBS_CYC_WAI      4'h9
`define CBS_CYC_RTI      4'hA
`define CBS_CYC_SWI      4'hC
`define CBS_WAI_CCR_OFS  16'h0006
`define CBS_SWI_LAST_OFS 16'h0007
`define CBS_RST_PC       16'h0000
`define CBS_RST_SP       16'h00FF
`endif

// File: cbs_idx_adder.sv
// Indexed effective address: index plus unsigned byte offset.
// Assumes combinational use inside the sequencer.
`timescale 1ns/10ps
module cbs_idx_adder
    import cbs_pkg::*;
(
    input  wire logic [15:0] i_index,
    input  wire logic [7:0]  i_offset,
    output logic      [15:0] o_ea
);
    assign o_ea = i_index + {8'h00, i_offset};
endmodule // cbs_idx_adder

// File: cbs_mem_model.sv
// Far-side memory model: answers qualified reads with an address pattern.
// Assumes registered bus pins from the sequencer and one shared clock.
`timescale 1ns/10ps
module cbs_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_vma,
    input  wire logic        i_rw,
    input  wire logic        i_addr_oe,
    input  wire logic [15:0] i_addr,
    output logic      [7:0]  o_din
);
    logic [7:0] last_q = 8'h00;
    logic       sel;
    assign sel = i_vma && i_rw && i_addr_oe;
    // Unqualified: bus left floating, shown as inverse of last byte
    assign o_din = sel ? (i_addr[7:0] ^ 8'h5A) : ~last_q;
    always_ff @(posedge i_clk) begin
        last_q <= o_din;
    end
endmodule // cbs_mem_model

// File: cbs_pin_drv.sv
// Registers the bus cycle onto the pins with three-state enables.
// Assumes the far side resolves the wires from the enables.
`timescale 1ns/10ps
module cbs_pin_drv
    import cbs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    cbs_bus_if.pin           bus,
    output logic             o_vma,
    output logic [15:0]      o_addr,
    output logic             o_addr_oe,
    output logic             o_rw,
    output logic             o_rw_oe,
    output logic [7:0]       o_data,
    output logic             o_data_oe,
    output logic             o_ba
);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_vma     <= 1'b0;
            o_addr    <= 16'h0000;
            o_addr_oe <= 1'b0;
            o_rw      <= 1'b1;
            o_rw_oe   <= 1'b0;
            o_data    <= 8'h00;
            o_data_oe <= 1'b0;
            o_ba      <= 1'b0;
        end else begin
            o_vma     <= bus.valid_memory_qualifier && !bus.float_bus;
            o_addr    <= bus.addr;
            o_addr_oe <= !bus.float_bus;
            o_rw      <= bus.rd;
            o_rw_oe   <= !bus.float_bus;
            o_data    <= bus.wdata;
            o_data_oe <= !bus.rd && !bus.float_bus;
            o_ba      <= bus.float_bus;
        end
    end
    a_float_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_ba |-> !o_vma && !o_addr_oe && !o_rw_oe && !o_data_oe)
        else $error("bus not floated while bus available");
    a_vma_low_nodrv: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (!o_vma && o_rw) |-> !o_data_oe)
        else $error("data driven in unqualified read");
endmodule // cbs_pin_drv

// File: cbs_pkg.sv
// Types shared by the bus cycle sequencer modules.
// Assumes cbs_defs.svh is on the include path.
package cbs_pkg;
    typedef enum logic [4:0] {
        CBS_OP_INH, CBS_OP_REG, CBS_OP_PSH, CBS_OP_PUL, CBS_OP_RTS,
        CBS_OP_WAI, CBS_OP_RTI, CBS_OP_SWI,
        CBS_OP_IMM8, CBS_OP_IMM16, CBS_OP_DIR8, CBS_OP_DIR16,
        CBS_OP_DSTA, CBS_OP_DST16, CBS_OP_EXT8, CBS_OP_EXT16,
        CBS_OP_ESTA, CBS_OP_EST16, CBS_OP_JMP, CBS_OP_JSR,
        CBS_OP_RMW, CBS_OP_TST, CBS_OP_IDX
    } cbs_class_t;
    typedef enum logic [1:0] {
        CBS_REG_INX, CBS_REG_DEX, CBS_REG_TSX, CBS_REG_TXS
    } cbs_regop_t;
endpackage

// File: cbs_sequencer.sv
// Cycle-by-cycle bus sequencer for one instruction at a time.
// Assumes the decode side gives a class on i_start; registers are inputs.
`timescale 1ns/10ps
`include "cbs_defs.svh"
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_start,
    input  wire cbs_class_t       i_class,
    input  wire cbs_regop_t       i_regop,
    input  wire logic             i_irq,
    input  wire logic [15:0]      i_pc,
    input  wire logic [15:0]      i_sp,
    input  wire logic [15:0]      i_ix,
    input  wire logic [7:0]       i_acca,
    input  wire logic [7:0]       i_accb,
    input  wire logic [7:0]       i_ccr,
    input  wire logic [7:0]       i_wval_hi,
    input  wire logic [7:0]       i_wval_lo,
    input  wire logic [7:0]       i_din,
    output logic                  o_vma,
    output logic [15:0]           o_addr,
    output logic                  o_addr_oe,
    output logic                  o_rw,
    output logic                  o_rw_oe,
    output logic [7:0]            o_data,
    output logic                  o_data_oe,
    output logic                  o_ba,
    output logic                  o_busy,
    output logic                  o_data_take,
    output logic [7:0]            o_rdata
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {CBS_ST_IDLE, CBS_ST_RUN, CBS_ST_WAIT} cbs_state_t;
    cbs_state_t  state_q;
    cbs_class_t  cls_q;
    cbs_regop_t  rop_q;
    logic [3:0]  cyc_q;
    logic [3:0]  last_q;
    logic [15:0] pc_q, sp_q, ix_q, ea_q;
    logic [7:0]  a_q, b_q, cc_q, whi_q, wlo_q;
    logic [15:0] idx_ea;
    logic [15:0] ea_c;
    logic        vma_c, rd_c, take_c, take_q;
    logic [15:0] addr_c;
    logic [7:0]  wd_c;
    logic [3:0]  last_c;

    cbs_bus_if bus ();

    cbs_idx_adder u_idx (
        .i_index (ix_q),
        .i_offset(i_din),
        .o_ea    (idx_ea)
    );

    cbs_pin_drv u_pin (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .bus      (bus),
        .o_vma    (o_vma),
        .o_addr   (o_addr),
        .o_addr_oe(o_addr_oe),
        .o_rw     (o_rw),
        .o_rw_oe  (o_rw_oe),
        .o_data   (o_data),
        .o_data_oe(o_data_oe),
        .o_ba     (o_ba)
    );

    // ****************************************
    // Cycle counts per class
    // ****************************************
    always_comb begin
        case (i_class)
            CBS_OP_INH:   last_c = `CBS_CYC_INH;
            CBS_OP_REG:   last_c = `CBS_CYC_REG;
            CBS_OP_PSH,
            CBS_OP_PUL:   last_c = `CBS_CYC_PSH;
            CBS_OP_RTS:   last_c = `CBS_CYC_RTS;
            CBS_OP_WAI:   last_c = `CBS_CYC_WAI;
            CBS_OP_RTI:   last_c = `CBS_CYC_RTI;
            CBS_OP_SWI:   last_c = `CBS_CYC_SWI;
            CBS_OP_IMM8:  last_c = 4'h2;
            CBS_OP_IMM16: last_c = 4'h3;
            CBS_OP_DIR8:  last_c = 4'h3;
            CBS_OP_DIR16: last_c = 4'h4;
            CBS_OP_DSTA:  last_c = 4'h4;
            CBS_OP_DST16: last_c = 4'h5;
            CBS_OP_EXT8:  last_c = 4'h4;
            CBS_OP_EXT16: last_c = 4'h5;
            CBS_OP_ESTA:  last_c = 4'h5;
            CBS_OP_EST16: last_c = 4'h6;
            CBS_OP_JMP:   last_c = 4'h3;
            CBS_OP_JSR:   last_c = 4'h9;
            CBS_OP_RMW,
            CBS_OP_TST:   last_c = 4'h6;
            CBS_OP_IDX:   last_c = 4'h5;
            default:      last_c = `CBS_CYC_INH;
        endcase
    end

    // ****************************************
    // Sequence control
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= CBS_ST_IDLE;
            cyc_q   <= 4'h0;
            last_q  <= 4'h0;
            cls_q   <= CBS_OP_INH;
            rop_q   <= CBS_REG_INX;
        end else begin
            case (state_q)
                CBS_ST_IDLE: begin
                    if (i_start) begin
                        state_q <= CBS_ST_RUN;
                        cyc_q   <= 4'h1;
                        last_q  <= last_c;
                        cls_q   <= i_class;
                        rop_q   <= i_regop;
                    end
                end
                CBS_ST_RUN: begin
                    if (cyc_q == last_q) begin
                        state_q <= (cls_q == CBS_OP_WAI) ? CBS_ST_WAIT : CBS_ST_IDLE;
                        cyc_q   <= 4'h0;
                    end else begin
                        cyc_q <= cyc_q + 4'h1;
                    end
                end
                CBS_ST_WAIT: begin
                    if (i_irq) begin
                        state_q <= CBS_ST_IDLE;
                    end
                end
                default: state_q <= CBS_ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // Register snapshot and captured operands
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_q  <= `CBS_RST_PC;
            sp_q  <= `CBS_RST_SP;
            ix_q  <= 16'h0000;
            a_q   <= 8'h00;
            b_q   <= 8'h00;
            cc_q  <= 8'h00;
            whi_q <= 8'h00;
            wlo_q <= 8'h00;
        end else if (state_q == CBS_ST_IDLE && i_start) begin
            pc_q  <= i_pc;
            sp_q  <= i_sp;
            ix_q  <= i_ix;
            a_q   <= i_acca;
            b_q   <= i_accb;
            cc_q  <= i_ccr;
            whi_q <= i_wval_hi;
            wlo_q <= i_wval_lo;
        end
    end

    // Operand address: bytes of pin cycles 2 and 3 arrive one clock late
    always_comb begin
        ea_c = ea_q;
        if (cyc_q == 4'h3) begin
            case (cls_q)
                CBS_OP_DIR8, CBS_OP_DIR16,
                CBS_OP_DSTA, CBS_OP_DST16: ea_c = {8'h00, i_din};
                CBS_OP_IDX:                ea_c = idx_ea;
                CBS_OP_EXT8, CBS_OP_EXT16, CBS_OP_ESTA, CBS_OP_EST16,
                CBS_OP_JSR, CBS_OP_RMW, CBS_OP_TST: ea_c = {i_din, 8'h00};
                default:                   ea_c = ea_q;
            endcase
        end else if (cyc_q == 4'h4) begin
            case (cls_q)
                CBS_OP_EXT8, CBS_OP_EXT16, CBS_OP_ESTA, CBS_OP_EST16,
                CBS_OP_JSR, CBS_OP_RMW, CBS_OP_TST: ea_c = {ea_q[15:8], i_din};
                default: ea_c = ea_q;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ea_q <= 16'h0000;
        end else if (state_q == CBS_ST_RUN && (cyc_q == 4'h3 || cyc_q == 4'h4)) begin
            ea_q <= ea_c;
        end
    end

    // ****************************************
    // Per-cycle bus decode
    // ****************************************
    always_comb begin
        vma_c  = 1'b1;
        rd_c   = 1'b1;
        addr_c = pc_q;
        wd_c   = 8'h00;
        take_c = 1'b0;
        if (cyc_q == 4'h2) begin
            addr_c = pc_q + 16'h0001;
            take_c = 1'b1;
        end else if (cyc_q == 4'h3) begin
            addr_c = pc_q + 16'h0002;
            take_c = 1'b1;
        end
        case (cls_q)
            CBS_OP_REG: if (cyc_q >= 4'h3) begin
                vma_c  = 1'b0;
                take_c = 1'b0;
                case (rop_q)
                    CBS_REG_INX: addr_c = (cyc_q == 4'h3) ? ix_q : ix_q + 16'h0001;
                    CBS_REG_DEX: addr_c = (cyc_q == 4'h3) ? ix_q : ix_q - 16'h0001;
                    CBS_REG_TSX: addr_c = (cyc_q == 4'h3) ? sp_q : sp_q + 16'h0001;
                    default:     addr_c = (cyc_q == 4'h3) ? ix_q : ix_q - 16'h0001;
                endcase
            end
            CBS_OP_PSH: if (cyc_q == 4'h3) begin
                addr_c = sp_q;
                rd_c   = 1'b0;
                wd_c   = a_q;
                take_c = 1'b0;
            end else if (cyc_q == 4'h4) begin
                addr_c = sp_q - 16'h0001;
                vma_c  = 1'b0;
                wd_c   = a_q;
            end
            CBS_OP_PUL, CBS_OP_RTS, CBS_OP_RTI: begin
                if (cyc_q == 4'h2) begin
                    take_c = (cls_q == CBS_OP_PUL);
                end else if (cyc_q == 4'h3) begin
                    addr_c = sp_q;
                    vma_c  = 1'b0;
                    take_c = 1'b0;
                end else if (cyc_q >= 4'h4) begin
                    addr_c = sp_q + {12'h000, cyc_q - 4'h3};
                    take_c = 1'b1;
                end
            end
            CBS_OP_WAI, CBS_OP_SWI: begin
                if (cyc_q == 4'h2) begin
                    take_c = 1'b0;
                end else if (cyc_q >= 4'h3 && cyc_q <= 4'h9) begin
                    addr_c = sp_q - {12'h000, cyc_q - 4'h3};
                    rd_c   = (cls_q == CBS_OP_WAI && cyc_q == 4'h9);
                    take_c = 1'b0;
                    case (cyc_q)
                        4'h3:    wd_c = pc_q[7:0];
                        4'h4:    wd_c = pc_q[15:8];
                        4'h5:    wd_c = ix_q[7:0];
                        4'h6:    wd_c = ix_q[15:8];
                        4'h7:    wd_c = a_q;
                        4'h8:    wd_c = b_q;
                        default: wd_c = cc_q;
                    endcase
                end else if (cyc_q == 4'hA) begin
                    addr_c = sp_q - `CBS_SWI_LAST_OFS;
                    vma_c  = 1'b0;
                end else if (cyc_q >= 4'hB) begin
                    addr_c = (cyc_q == 4'hB) ? `CBS_VEC_HI : `CBS_VEC_LO;
                    take_c = 1'b1;
                end
            end
            CBS_OP_DIR8, CBS_OP_DIR16, CBS_OP_DSTA, CBS_OP_DST16: begin
                if (cyc_q >= 4'h3) begin
                    addr_c = (cyc_q == 4'h5 ||
                              (cls_q == CBS_OP_DIR16 && cyc_q == 4'h4))
                             ? ea_c + 16'h0001 : ea_c;
                    if (cls_q == CBS_OP_DSTA || cls_q == CBS_OP_DST16) begin
                        vma_c  = (cyc_q != 4'h3);
                        rd_c   = (cyc_q == 4'h3);
                        take_c = 1'b0;
                        wd_c   = (cls_q == CBS_OP_DSTA) ? a_q :
                                 (cyc_q == 4'h4) ? whi_q : wlo_q;
                    end
                end
            end
            CBS_OP_EXT8, CBS_OP_EXT16, CBS_OP_ESTA, CBS_OP_EST16,
            CBS_OP_RMW, CBS_OP_TST: begin
                if (cyc_q >= 4'h4) begin
                    addr_c = ((cls_q == CBS_OP_EXT16 || cls_q == CBS_OP_EST16)
                              && cyc_q == (last_q)) ? ea_c + 16'h0001 : ea_c;
                    case (cls_q)
                        CBS_OP_ESTA, CBS_OP_EST16: begin
                            vma_c  = (cyc_q != 4'h4);
                            rd_c   = (cyc_q == 4'h4);
                            take_c = 1'b0;
                            wd_c   = (cls_q == CBS_OP_ESTA) ? a_q :
                                     (cyc_q == 4'h5) ? whi_q : wlo_q;
                        end
                        CBS_OP_RMW, CBS_OP_TST: begin
                            vma_c  = (cyc_q == 4'h4) ||
                                     (cyc_q == 4'h6 && cls_q == CBS_OP_RMW);
                            rd_c   = (cyc_q != 4'h6);
                            take_c = (cyc_q == 4'h4);
                            wd_c   = wlo_q;
                        end
                        default: take_c = 1'b1;
                    endcase
                end
            end
            CBS_OP_JSR: begin
                case (cyc_q)
                    4'h4: addr_c = ea_c;
                    4'h5: begin
                        addr_c = sp_q;
                        rd_c   = 1'b0;
                        wd_c   = pc_q[7:0] + 8'h03;
                    end
                    4'h6: begin
                        addr_c = sp_q - 16'h0001;
                        rd_c   = 1'b0;
                        wd_c   = pc_q[15:8];
                    end
                    4'h7: begin
                        addr_c = sp_q - 16'h0002;
                        vma_c  = 1'b0;
                    end
                    4'h8, 4'h9: begin
                        addr_c = pc_q + 16'h0002;
                        vma_c  = (cyc_q == 4'h9);
                    end
                    default: addr_c = addr_c;
                endcase
                take_c = take_c && cyc_q <= 4'h3;
            end
            CBS_OP_IDX: if (cyc_q >= 4'h3) begin
                addr_c = (cyc_q == 4'h3) ? ix_q : ea_q;
                vma_c  = (cyc_q == 4'h5);
                take_c = (cyc_q == 4'h5);
            end
            default: vma_c = 1'b1;
        endcase
        if (state_q != CBS_ST_RUN) begin
            vma_c  = 1'b0;
            rd_c   = 1'b1;
            take_c = 1'b0;
        end
    end

    assign bus.valid_memory_qualifier       = vma_c;
    assign bus.addr      = addr_c;
    assign bus.rd        = rd_c;
    assign bus.wdata     = wd_c;
    assign bus.float_bus = (state_q == CBS_ST_WAIT);

    // ****************************************
    // Status outputs
    // ****************************************
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_busy      <= 1'b0;
            take_q      <= 1'b0;
            o_data_take <= 1'b0;
            o_rdata     <= 8'h00;
        end else begin
            o_busy      <= (state_q != CBS_ST_IDLE);
            take_q      <= take_c && vma_c;
            o_data_take <= take_q;
            o_rdata     <= i_din;
        end
    end

    a_swi_vector: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_SWI && cyc_q == 4'hB)
        |=> o_addr == 16'hFFFA ##1 o_addr == 16'hFFFB)
        else $error("trap vector address wrong");
    a_wai_enter: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_WAI && cyc_q == 4'h9)
        |=> ##1 o_ba)
        else $error("bus available not raised");
    a_tst_novma: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_TST && cyc_q == 4'h6)
        |=> !o_vma)
        else $error("test op qualified last cycle");
    a_rts_discard: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_RTS && cyc_q == 4'h2)
        |=> ##1 !o_data_take)
        else $error("return cycle two data taken");
    a_psh_write: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_PSH && cyc_q == 4'h3)
        |=> (!o_rw && o_vma && o_addr == sp_q) ##1 !o_vma)
        else $error("push cycles wrong");
    a_inh_len: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_IDLE && i_start && i_class == CBS_OP_INH)
        |=> state_q == CBS_ST_RUN ##1 state_q == CBS_ST_RUN ##1 state_q == CBS_ST_IDLE)
        else $error("inherent op length wrong");
    a_take_qual: assert property (@(posedge i_clk) disable iff (!i_rstn)
        take_q |-> o_vma && o_rw)
        else $error("data taken in unqualified cycle");
    a_reg_novma: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_REG && cyc_q >= 4'h3)
        |=> !o_vma && o_rw)
        else $error("register op tail qualified");
    a_rti_addr: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (state_q == CBS_ST_RUN && cls_q == CBS_OP_RTI && cyc_q == 4'hA)
        |=> o_addr == sp_q + 16'h0007)
        else $error("interrupt return last address wrong");
endmodule // cbs_sequencer

// File: tb_top.sv
// Testbench for the bus cycle sequencer: table of cycles, then wait state.
// Assumes cbs_pkg, the sequencer and the memory model are compiled first.
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
    import cbs_pkg::*;
    typedef struct {cbs_class_t c; int k; logic [17:0] e; logic [7:0] d;} cbs_row_t;
    logic        i_clk = 0, i_rstn = 0, i_start = 0, i_irq = 0;
    cbs_class_t  i_class = CBS_OP_INH;
    cbs_regop_t  i_regop = CBS_REG_INX;
    logic [15:0] i_pc = 16'h1000, i_sp = 16'h01FF, i_ix = 16'h2000, o_addr;
    logic [7:0]  i_acca = 8'hA5, i_accb = 8'h96, i_ccr = 8'hC1, i_din, o_data, o_rdata;
    logic [7:0]  i_wval_hi = 8'hC3, i_wval_lo = 8'h3C;
    logic        o_vma, o_addr_oe, o_rw, o_rw_oe, o_data_oe, o_ba, o_busy, o_data_take;
    int          err_count = 0, check_count = 0, cyc = 0;
    cbs_row_t    rows[] = '{
        '{CBS_OP_INH, 2, 18'h31001, 8'h00}, '{CBS_OP_REG, 3, 18'h12000, 8'h00},
        '{CBS_OP_PSH, 3, 18'h201FF, 8'hA5}, '{CBS_OP_PSH, 4, 18'h101FE, 8'h00},
        '{CBS_OP_PUL, 3, 18'h101FF, 8'h00}, '{CBS_OP_PUL, 4, 18'h30200, 8'h00},
        '{CBS_OP_RTS, 5, 18'h30201, 8'h00}, '{CBS_OP_RTI, 10, 18'h30206, 8'h00},
        '{CBS_OP_SWI, 10, 18'h101F8, 8'h00}, '{CBS_OP_SWI, 11, 18'h3FFFA, 8'h00},
        '{CBS_OP_SWI, 12, 18'h3FFFB, 8'h00}, '{CBS_OP_IMM8, 2, 18'h31001, 8'h00},
        '{CBS_OP_IMM16, 3, 18'h31002, 8'h00}, '{CBS_OP_DIR8, 3, 18'h3005B, 8'h00},
        '{CBS_OP_DIR16, 4, 18'h3005C, 8'h00}, '{CBS_OP_DSTA, 3, 18'h1005B, 8'h00},
        '{CBS_OP_DSTA, 4, 18'h2005B, 8'hA5}, '{CBS_OP_DST16, 5, 18'h2005C, 8'h3C},
        '{CBS_OP_EXT8, 4, 18'h35B58, 8'h00}, '{CBS_OP_EXT16, 5, 18'h35B59, 8'h00},
        '{CBS_OP_ESTA, 4, 18'h15B58, 8'h00}, '{CBS_OP_EST16, 6, 18'h25B59, 8'h3C},
        '{CBS_OP_JMP, 3, 18'h31002, 8'h00}, '{CBS_OP_JSR, 5, 18'h201FF, 8'h03},
        '{CBS_OP_JSR, 7, 18'h101FD, 8'h00}, '{CBS_OP_RMW, 6, 18'h25B58, 8'h3C},
        '{CBS_OP_TST, 6, 18'h05B58, 8'h00}, '{CBS_OP_IDX, 5, 18'h3205B, 8'h00}};
    cbs_sequencer dut (.i_clk, .i_rstn, .i_start, .i_class, .i_regop, .i_irq, .i_pc, .i_sp,
        .i_ix, .i_acca, .i_accb, .i_ccr, .i_wval_hi, .i_wval_lo, .i_din, .o_vma, .o_addr,
        .o_addr_oe, .o_rw, .o_rw_oe, .o_data, .o_data_oe, .o_ba, .o_busy, .o_data_take, .o_rdata);
    cbs_mem_model mem (.i_clk(i_clk), .i_vma(o_vma), .i_rw(o_rw), .i_addr_oe(o_addr_oe),
        .i_addr(o_addr), .o_din(i_din));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    task final_report;
        $display("errors=%0d checks=%0d", err_count, check_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task go(input cbs_class_t c, input int k);
        @(posedge i_clk) begin i_class <= c; i_start <= 1'b1; end
        @(posedge i_clk) i_start <= 1'b0;
        repeat (k) @(posedge i_clk);
        #1;
    endtask
    task idle;
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 40) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        repeat (2) @(posedge i_clk);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge i_clk);
        #1 `CHK({o_vma, o_rw, o_ba, o_busy, o_addr_oe}, 5'b01000)
        @(posedge i_clk) i_rstn <= 1'b1;
        foreach (rows[i]) begin
            go(rows[i].c, rows[i].k);
            `CHK({o_vma, o_rw, o_addr}, rows[i].e)
            if (rows[i].e[17:16] == 2'b10) `CHK(o_data, rows[i].d)
            idle();
        end
        go(CBS_OP_WAI, 8);
        `CHK({o_vma, o_rw, o_addr, o_data}, {2'b10, 16'h01FA, 8'h96})
        @(posedge i_clk);
        #1 `CHK({o_vma, o_rw, o_addr}, {2'b11, 16'h01F9})
        repeat (3) @(posedge i_clk);
        @(posedge i_clk) i_start <= 1'b1;
        @(posedge i_clk) i_start <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 `CHK({o_ba, o_vma, o_addr_oe, o_rw_oe, o_data_oe}, 5'b10000)
        @(posedge i_clk) i_irq <= 1'b1;
        idle();
        @(posedge i_clk) i_irq <= 1'b0;
        #1 `CHK(o_ba, 1'b0)
        go(CBS_OP_PUL, 4);
        @(posedge i_clk);
        #1 `CHK({o_data_take, o_rdata}, 9'h15A)
        idle();
        go(CBS_OP_RTS, 2);
        @(posedge i_clk);
        #1 `CHK({o_data_take, o_busy}, 2'b01)
        idle();
        @(posedge i_clk) i_regop <= CBS_REG_TSX;
        go(CBS_OP_REG, 4);
        `CHK({o_vma, o_rw, o_addr}, 18'h10200)
        idle();
        @(posedge i_clk) i_regop <= CBS_REG_TXS;
        go(CBS_OP_REG, 4);
        `CHK({o_vma, o_rw, o_addr}, 18'h11FFF)
        idle();
        final_report();
    end
endmodule // tb_top
